// >>> hw/cmac_core.sv
/*
  CSMA/CD media access core: transmit framing, deferral and backoff, receive deframing,
  address filtering, frame checks, self-monitoring and word packing toward the receive FIFO.
  Assumes codec pins are asynchronous to core_clk and well below its rate; FIFO side is synchronous.
*/
// Function
// - External codec select high routes serial signals to the external codec pins.
// - Receiver waits for start delimiter 10101011, then assembles octets.
// - Destination address checked against table; only matching frames reach the FIFO.
// - Frame ends when carrier drops; alignment, CRC and runt checks posted.
// - During transmit, looped-back CRC and source address checked; mismatch flags bad.
// - Reception aborts on overrun, mismatch, no buffer, or rejected collision/error.
// - CRC checked over every received frame, including self-received ones.
// - Table holds sixteen loadable entries plus one fixed broadcast entry.
// - Transmit sends seven preamble bytes, start delimiter, data, optional CRC.
// - Collision sends four all-ones jam bytes, after preamble completes if needed.
// - Transmit defers while network busy, then waits 9.6 us gap.
// - Activity in first 6.4 us restarts gap; later activity ignored.
// - Backoff waits r slot times of 51.2 us, r from 0 to 2^min(n,10).
// - Collision on sixteenth attempt abandons frame with excessive collisions status.
// - Serializer shifts bytes out LSB first, one bit per transmit clock.
// - CRC inhibit input suppresses FCS generation for forwarded frames.
// - Every finished transmission, good or aborted, posts transmit status.
// - Width select picks 32 or 16 bit words; 16 bit uses low lines only.
// - Byte order low puts byte 0 in bits 7:0.
// - Byte order high puts byte 0 in the most significant lane.
// - Transmit bit clock comes from the codec at 10 MHz.
`timescale 1ns/10ps
`default_nettype none
`include "cmac_params.svh"

module cmac_core #(
  parameter int SLOT_CYC = `CMAC_SLOT_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic external_codec_select,
  input wire logic int_rx_data,
  input wire logic int_rx_clk,
  input wire logic int_carrier_sense_in,
  input wire logic int_collision,
  input wire logic int_transmit_bit_clock,
  input wire logic ext_rx_data,
  input wire logic ext_rx_clk,
  input wire logic ext_carrier_sense_in,
  input wire logic ext_collision,
  input wire logic ext_transmit_bit_clock,
  output logic int_tx_data_q,
  output logic int_tx_en_q,
  output logic ext_tx_data_q,
  output logic ext_tx_en_q,
  input wire logic tx_start,
  input wire logic tx_crc_inhibit,
  input wire logic [7:0] tx_byte,
  input wire logic tx_byte_valid,
  input wire logic tx_last,
  output logic tx_byte_take_q,
  output logic tx_retry_q,
  output logic tx_done_q,
  output logic tx_ok_q,
  output logic tx_excess_coll_q,
  output logic tx_underrun_q,
  output logic [4:0] tx_attempts_q,
  output logic monitored_frame_bad_q,
  input wire logic tbl_wr_en,
  input wire logic [3:0] tbl_wr_idx,
  input wire logic [47:0] tbl_wr_addr,
  input wire logic data_width_select,
  input wire logic byte_order_select,
  input wire logic loopback_transceiver,
  input wire logic reject_on_collision,
  input wire logic reject_on_error,
  input wire logic rx_fifo_overrun,
  input wire logic no_free_buffer,
  output logic [31:0] rx_word_q,
  output logic rx_word_valid_q,
  output logic rx_done_q,
  output logic rx_abort_q,
  output logic rx_crc_err_q,
  output logic rx_align_err_q,
  output logic rx_runt_q
);
  import cmac_pkg::*;

  // Two-stage synchronisers for every codec pin, internal and external alike
  wire [`CMAC_NSYNC-1:0] pin_raw = {external_codec_select, int_rx_data, int_rx_clk, int_carrier_sense_in,
    int_collision, int_transmit_bit_clock, ext_rx_data, ext_rx_clk, ext_carrier_sense_in, ext_collision,
    ext_transmit_bit_clock};
  logic [`CMAC_NSYNC-1:0] s1_q, s2_q;
  genvar gs;
  for (gs = 0; gs < `CMAC_NSYNC; gs++) begin : g_sync
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        s1_q[gs] <= 1'b0;
        s2_q[gs] <= 1'b0;
      end else begin
        s1_q[gs] <= pin_raw[gs];
        s2_q[gs] <= s1_q[gs];
      end
    end
  end

  wire ext_sel = s2_q[10];
  wire rxd = ext_sel ? s2_q[4] : s2_q[9];
  wire rxc = ext_sel ? s2_q[3] : s2_q[8];
  wire carrier_sense_in = ext_sel ? s2_q[2] : s2_q[7];
  wire col = ext_sel ? s2_q[1] : s2_q[6];
  wire transmit_bit_clock = ext_sel ? s2_q[0] : s2_q[5];
  logic rxc_prev_q, txc_prev_q;
  wire rxc_rise = rxc && !rxc_prev_q;
  wire txc_rise = transmit_bit_clock && !txc_prev_q;
  wire net_busy = carrier_sense_in || col;

  // Transmit sequencer
  cmac_tx_state_e tx_st_q, tx_st_d;
  logic [9:0] ifg_q, ifg_d;
  logic [5:0] cnt_q, cnt_d;
  logic [2:0] btc_q, btc_d;
  logic [7:0] sh_q, sh_d;
  logic [31:0] tcrc_q, tcrc_d;
  logic last_q, last_d, cpend_q, cpend_d, out_q, out_d, on_q, on_d;
  logic [4:0] att_d;
  logic [10:0] r_q, r_d;
  logic [15:0] slot_q, slot_d, lfsr_q;
  logic take_d, retry_d, done_d, ok_d, exc_d, und_d;

  // The nth retry follows the nth collision, so k counts the collision that ends this jam
  wire [4:0] bk_n = tx_attempts_q + 5'h01;
  wire [3:0] bk_k = (bk_n > 5'(`CMAC_BACKOFF_CAP)) ? `CMAC_BACKOFF_CAP : bk_n[3:0];
  wire [10:0] bk_mask = (11'h001 << bk_k) - 11'h001;
  // Extra LFSR bit lets r reach 2^k itself, as the inclusive range asks
  wire [10:0] bk_r = ({1'b0, lfsr_q[9:0]} & bk_mask) + {10'h000, lfsr_q[15]};
  wire [7:0] cur_byte = (btc_q == 3'h0) ? tx_byte : sh_q;
  wire tx_fb = cur_byte[0] ^ tcrc_q[0];
  wire tx_on = (tx_st_q == TX_PRE) || (tx_st_q == TX_DATA) || (tx_st_q == TX_FCS) || (tx_st_q == TX_JAM);

  always_comb begin
    tx_st_d = tx_st_q;
    ifg_d = ifg_q;
    cnt_d = cnt_q;
    btc_d = btc_q;
    sh_d = sh_q;
    tcrc_d = tcrc_q;
    last_d = last_q;
    cpend_d = cpend_q || (tx_st_q == TX_PRE && col);
    out_d = out_q;
    // Enable drops one bit clock after the last bit, so the final bit stands a full period
    on_d = on_q && !(txc_rise && !tx_on);
    att_d = tx_attempts_q;
    r_d = r_q;
    slot_d = slot_q;
    take_d = 1'b0;
    retry_d = 1'b0;
    done_d = 1'b0;
    ok_d = tx_ok_q;
    exc_d = tx_excess_coll_q;
    und_d = tx_underrun_q;
    unique case (tx_st_q)
      TX_IDLE: begin
        if (tx_start) begin
          att_d = 5'h00;
          ifg_d = 10'h000;
          tx_st_d = TX_DEFER;
        end
      end
      TX_DEFER: begin
        if (net_busy && (ifg_q < 10'(`CMAC_IFG1_CYC))) begin
          ifg_d = 10'h000;
        end else if (ifg_q == 10'(`CMAC_IFG_CYC - 1)) begin
          tx_st_d = TX_PRE;
          cnt_d = 6'h00;
          cpend_d = 1'b0;
          tcrc_d = `CMAC_CRC_INIT;
        end else begin
          ifg_d = ifg_q + 10'h001;
        end
      end
      TX_PRE: if (txc_rise) begin
        out_d = (cnt_q >= `CMAC_PRE_SFD_BIT) ? 1'b1 : ~cnt_q[0];
        on_d = 1'b1;
        cnt_d = cnt_q + 6'h01;
        btc_d = 3'h0;
        if (cnt_q == `CMAC_PRE_LAST) begin
          tx_st_d = (cpend_d || col) ? TX_JAM : TX_DATA;
          cnt_d = 6'h00;
        end
      end
      TX_DATA: if (txc_rise) begin
        if (col) begin
          tx_st_d = TX_JAM;
          cnt_d = 6'h01;
          out_d = 1'b1;
        end else if (btc_q == 3'h0 && !tx_byte_valid) begin
          und_d = 1'b1;
          on_d = 1'b0;
          ok_d = 1'b0;
          exc_d = 1'b0;
          done_d = 1'b1;
          tx_st_d = TX_IDLE;
        end else begin
          out_d = cur_byte[0];
          sh_d = {1'b0, cur_byte[7:1]};
          tcrc_d = {1'b0, tcrc_q[31:1]} ^ (tx_fb ? `CMAC_CRC_POLY : 32'h00000000);
          btc_d = btc_q + 3'h1;
          if (btc_q == 3'h0) begin
            take_d = 1'b1;
            last_d = tx_last;
          end
          if (btc_q == `CMAC_BYTE_LAST && last_q) begin
            cnt_d = 6'h00;
            if (tx_crc_inhibit) begin
              tx_st_d = TX_IDLE;
              done_d = 1'b1;
              ok_d = 1'b1;
              exc_d = 1'b0;
              und_d = 1'b0;
            end else begin
              tx_st_d = TX_FCS;
            end
          end
        end
      end
      TX_FCS: if (txc_rise) begin
        if (col) begin
          tx_st_d = TX_JAM;
          cnt_d = 6'h01;
          out_d = 1'b1;
        end else begin
          out_d = ~tcrc_q[0];
          tcrc_d = {1'b1, tcrc_q[31:1]};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == `CMAC_QUAD_LAST) begin
            tx_st_d = TX_IDLE;
            done_d = 1'b1;
            ok_d = 1'b1;
            exc_d = 1'b0;
            und_d = 1'b0;
          end
        end
      end
      TX_JAM: if (txc_rise) begin
        out_d = 1'b1;
        cnt_d = cnt_q + 6'h01;
        if (cnt_q == `CMAC_QUAD_LAST) begin
          att_d = tx_attempts_q + 5'h01;
          if (tx_attempts_q == `CMAC_LAST_ATTEMPT) begin
            tx_st_d = TX_IDLE;
            done_d = 1'b1;
            ok_d = 1'b0;
            exc_d = 1'b1;
            und_d = 1'b0;
          end else begin
            tx_st_d = TX_BACKOFF;
            r_d = bk_r;
            slot_d = 16'h0000;
          end
        end
      end
      TX_BACKOFF: begin
        // Retry waits until the last jam bit has left, so the gap never overlaps it
        if (r_q == 11'h000) begin
          if (!on_q) begin
            tx_st_d = TX_DEFER;
            ifg_d = 10'h000;
            retry_d = 1'b1;
          end
        end else if (slot_q == 16'(SLOT_CYC - 1)) begin
          slot_d = 16'h0000;
          r_d = r_q - 11'h001;
        end else begin
          slot_d = slot_q + 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_q <= TX_IDLE;
      {ifg_q, cnt_q, btc_q, sh_q, last_q, cpend_q, out_q, on_q, r_q, slot_q} <= '0;
      tcrc_q <= `CMAC_CRC_INIT;
      lfsr_q <= `CMAC_LFSR_SEED;
      {tx_attempts_q, tx_byte_take_q, tx_retry_q, tx_done_q, tx_ok_q, tx_excess_coll_q, tx_underrun_q} <= '0;
      {rxc_prev_q, txc_prev_q, int_tx_data_q, int_tx_en_q, ext_tx_data_q, ext_tx_en_q} <= '0;
    end else begin
      tx_st_q <= tx_st_d;
      {ifg_q, cnt_q, btc_q, sh_q, last_q, cpend_q, out_q, on_q, r_q, slot_q} <=
        {ifg_d, cnt_d, btc_d, sh_d, last_d, cpend_d, out_d, on_d, r_d, slot_d};
      tcrc_q <= tcrc_d;
      lfsr_q <= {1'b0, lfsr_q[15:1]} ^ (lfsr_q[0] ? `CMAC_LFSR_TAPS : 16'h0000);
      {tx_attempts_q, tx_byte_take_q, tx_retry_q, tx_done_q, tx_ok_q, tx_excess_coll_q, tx_underrun_q} <=
        {att_d, take_d, retry_d, done_d, ok_d, exc_d, und_d};
      rxc_prev_q <= rxc;
      txc_prev_q <= transmit_bit_clock;
      int_tx_data_q <= out_d && on_d && !ext_sel;
      int_tx_en_q <= on_d && !ext_sel;
      ext_tx_data_q <= out_d && on_d && ext_sel;
      ext_tx_en_q <= on_d && ext_sel;
    end
  end

  // Receive sequencer; self-reception is any frame whose carrier rises while transmitting
  cmac_rx_state_e rx_st_q, rx_st_d;
  logic [7:0] rsr_q, rsr_d, rbyte_q, rbyte_d;
  logic [2:0] rbc_q, rbc_d;
  logic [31:0] rcrc_q, rcrc_d;
  logic [10:0] nby_q, nby_d;
  logic [47:0] addr_q, addr_d;
  logic self_q, self_d, stb_q, stb_d, abrt_q, abrt_d, mok_q, mok_d, cmp_req_d, cmp_req_q;
  logic fin_d, crc_e_d, aln_e_d, runt_d, mfb_d;
  logic hit_q, hit_valid_q;

  wire [7:0] rsr_next = {rxd, rsr_q[7:1]};
  wire [10:0] addr_first = self_q ? `CMAC_ADDR_FIRST_SA : `CMAC_ADDR_FIRST_DA;
  wire in_addr = (nby_q >= addr_first) && (nby_q < addr_first + `CMAC_ADDR_LEN);
  wire addr_done = stb_q && (nby_q == addr_first + `CMAC_ADDR_LEN - 11'h001);
  wire crc_bad = (rcrc_q != `CMAC_CRC_RESID);
  wire store_ok = mok_q && (!self_q || loopback_transceiver);
  wire store_stb = stb_q && store_ok && (nby_q >= `CMAC_ADDR_LEN) && (rx_st_q == RX_DATA);
  wire hard_abort = rx_fifo_overrun || no_free_buffer || (reject_on_collision && col) ||
    (hit_valid_q && !hit_q && !self_q);

  always_comb begin
    rx_st_d = rx_st_q;
    rsr_d = rsr_q;
    rbyte_d = rbyte_q;
    rbc_d = rbc_q;
    rcrc_d = rcrc_q;
    nby_d = stb_q ? nby_q + 11'h001 : nby_q;
    addr_d = (stb_q && in_addr) ? {rbyte_q, addr_q[47:8]} : addr_q;
    self_d = self_q;
    stb_d = 1'b0;
    abrt_d = abrt_q;
    mok_d = mok_q || (hit_valid_q && hit_q);
    cmp_req_d = addr_done;
    fin_d = 1'b0;
    crc_e_d = crc_bad;
    aln_e_d = (rbc_q != 3'h0);
    runt_d = (nby_q < `CMAC_MIN_FRAME);
    mfb_d = monitored_frame_bad_q;
    unique case (rx_st_q)
      RX_IDLE: if (carrier_sense_in) begin
        rx_st_d = RX_HUNT;
        rsr_d = 8'h00;
        self_d = tx_on || on_q;
      end
      RX_HUNT: begin
        if (!carrier_sense_in) begin
          rx_st_d = RX_IDLE;
        end else if (rxc_rise) begin
          rsr_d = rsr_next;
          if (rsr_next == `CMAC_SFD) begin
            rx_st_d = RX_DATA;
            rbc_d = 3'h0;
            nby_d = 11'h000;
            rcrc_d = `CMAC_CRC_INIT;
            abrt_d = 1'b0;
            mok_d = 1'b0;
          end
        end
      end
      RX_DATA, RX_DISCARD: begin
        if (rxc_rise) begin
          rsr_d = rsr_next;
          rcrc_d = {1'b0, rcrc_q[31:1]} ^ ((rxd ^ rcrc_q[0]) ? `CMAC_CRC_POLY : 32'h00000000);
          rbc_d = rbc_q + 3'h1;
          if (rbc_q == `CMAC_BYTE_LAST) begin
            stb_d = 1'b1;
            rbyte_d = rsr_next;
          end
        end
        if (rx_st_q == RX_DATA && hard_abort) begin
          rx_st_d = RX_DISCARD;
          abrt_d = 1'b1;
        end
        if (!carrier_sense_in) begin
          rx_st_d = RX_IDLE;
          fin_d = 1'b1;
          if (self_q) begin
            mfb_d = crc_bad || !mok_q;
          end
        end
      end
    endcase
  end

  logic [31:0] word_q, word_d, fill_word;
  logic [1:0] lane_cnt_q;
  wire [1:0] lane_top = data_width_select ? 2'h3 : 2'h1;
  wire [1:0] lane_sel = byte_order_select ? (lane_top - lane_cnt_q) : lane_cnt_q;
  wire word_full = store_stb && (lane_cnt_q == lane_top);
  wire word_tail = fin_d && (lane_cnt_q != 2'h0) && !abrt_q;
  // Unused upper half stays zero in 16-bit mode; partial words are padded with fill bytes
  assign fill_word = data_width_select ? {4{`CMAC_FILL_BYTE}} : {16'h0000, {2{`CMAC_FILL_BYTE}}};
  genvar gl;
  for (gl = 0; gl < 4; gl++) begin : g_lane
    assign word_d[gl*8 +: 8] = (store_stb && lane_sel == 2'(gl)) ? rbyte_q : word_q[gl*8 +: 8];
  end
  wire rej_err = reject_on_error && (crc_e_d || aln_e_d) && !self_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_q <= RX_IDLE;
      {rsr_q, rbyte_q, rbc_q, nby_q, addr_q, self_q, stb_q, abrt_q, mok_q, cmp_req_q} <= '0;
      rcrc_q <= `CMAC_CRC_INIT;
      {rx_done_q, rx_abort_q, rx_crc_err_q, rx_align_err_q, rx_runt_q, monitored_frame_bad_q} <= '0;
      {word_q, lane_cnt_q, rx_word_q, rx_word_valid_q} <= '0;
    end else begin
      rx_st_q <= rx_st_d;
      {rsr_q, rbyte_q, rbc_q, nby_q, addr_q, self_q, stb_q, abrt_q, mok_q, cmp_req_q} <=
        {rsr_d, rbyte_d, rbc_d, nby_d, addr_d, self_d, stb_d, abrt_d, mok_d, cmp_req_d};
      rcrc_q <= rcrc_d;
      monitored_frame_bad_q <= mfb_d;
      rx_done_q <= fin_d && !self_q;
      if (fin_d && !self_q) begin
        rx_abort_q <= abrt_q || rej_err;
        rx_crc_err_q <= crc_e_d;
        rx_align_err_q <= aln_e_d;
        rx_runt_q <= runt_d;
      end
      rx_word_valid_q <= word_full || word_tail;
      if (word_full || word_tail) begin
        rx_word_q <= word_d;
      end
      word_q <= (word_full || fin_d || rx_st_q == RX_HUNT) ? fill_word : word_d;
      lane_cnt_q <= (word_full || fin_d || rx_st_q == RX_HUNT) ? 2'h0 : (store_stb ? lane_cnt_q + 2'h1 : lane_cnt_q);
    end
  end

  cmac_addr_table u_tbl (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wr_en(tbl_wr_en),
    .wr_idx(tbl_wr_idx),
    .wr_addr(tbl_wr_addr),
    .cmp_req(cmp_req_q),
    .cmp_addr(addr_q),
    .hit_q(hit_q),
    .hit_valid_q(hit_valid_q)
  );
endmodule : cmac_core
`default_nettype wire

// >>> hw/cmac_params.svh
/*
  Constants for the CSMA/CD media access core: frame patterns, CRC, timing and table sizes.
  Assumes a 100 MHz core clock; included by bare name, definitions only.
*/
`ifndef CMAC_PARAMS_SVH
`define CMAC_PARAMS_SVH

`define CMAC_SFD 8'hD5
`define CMAC_PRE_LAST 6'h3F
`define CMAC_PRE_SFD_BIT 6'h3E
`define CMAC_QUAD_LAST 6'h1F
`define CMAC_BYTE_LAST 3'h7
`define CMAC_CRC_INIT 32'hFFFFFFFF
`define CMAC_CRC_POLY 32'hEDB88320
`define CMAC_CRC_RESID 32'hDEBB20E3
`define CMAC_CLK_NS 10
`define CMAC_IFG_NS 9600
`define CMAC_IFG1_NS 6400
`define CMAC_SLOT_NS 51200
`define CMAC_IFG_CYC (`CMAC_IFG_NS / `CMAC_CLK_NS)
`define CMAC_IFG1_CYC (`CMAC_IFG1_NS / `CMAC_CLK_NS)
`define CMAC_SLOT_CYC (`CMAC_SLOT_NS / `CMAC_CLK_NS)
`define CMAC_LAST_ATTEMPT 5'h0F
`define CMAC_BACKOFF_CAP 4'hA
`define CMAC_MIN_FRAME 11'h040
`define CMAC_ADDR_FIRST_DA 11'h000
`define CMAC_ADDR_FIRST_SA 11'h006
`define CMAC_ADDR_LEN 11'h006
`define CMAC_BCAST 48'hFFFFFFFFFFFF
`define CMAC_FILL_BYTE 8'hFF
`define CMAC_TBL_ENTRIES 16
`define CMAC_LFSR_SEED 16'hACE1
`define CMAC_LFSR_TAPS 16'hB400
`define CMAC_NSYNC 11

`endif

// >>> hw/cmac_pkg.sv
/*
  Types for the CSMA/CD media access core: transmit and receive sequencer states.
  No assumptions beyond a SystemVerilog tool.
*/
package cmac_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_DEFER, TX_PRE, TX_DATA, TX_FCS, TX_JAM, TX_BACKOFF} cmac_tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_DATA, RX_DISCARD} cmac_rx_state_e;
endpackage : cmac_pkg

// >>> hw/cmac_addr_table.sv
/*
  Address filter table: sixteen loadable entries plus a fixed broadcast entry, compared in parallel.
  Assumes writes and compare requests come from the core clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cmac_params.svh"

module cmac_addr_table (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [47:0] wr_addr,
  input wire logic cmp_req,
  input wire logic [47:0] cmp_addr,
  output logic hit_q,
  output logic hit_valid_q
);
  logic [47:0] ent_q [`CMAC_TBL_ENTRIES];
  logic [`CMAC_TBL_ENTRIES-1:0] used_q;
  logic [`CMAC_TBL_ENTRIES-1:0] ent_hit;
  wire bcast_hit = (cmp_addr == `CMAC_BCAST);

  // Unwritten entries never match, so a zero address is not accepted by accident
  genvar gi;
  for (gi = 0; gi < `CMAC_TBL_ENTRIES; gi++) begin : g_ent
    assign ent_hit[gi] = used_q[gi] && (ent_q[gi] == cmp_addr);
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        ent_q[gi] <= 48'h000000000000;
        used_q[gi] <= 1'b0;
      end else if (wr_en && (wr_idx == 4'(gi))) begin
        ent_q[gi] <= wr_addr;
        used_q[gi] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hit_q <= 1'b0;
      hit_valid_q <= 1'b0;
    end else begin
      hit_valid_q <= cmp_req;
      if (cmp_req) begin
        hit_q <= bcast_hit || (|ent_hit);
      end
    end
  end
endmodule : cmac_addr_table
`default_nettype wire

// >>> dv/cmac_core_asserts.sv
/*
  Port checker for cmac_core: routing, deferral, retry, pulse and packing relations.
  Bound to every cmac_core instance; one core clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module cmac_core_asserts (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic external_codec_select,
  input wire logic int_tx_en_q,
  input wire logic ext_tx_en_q,
  input wire logic tx_start,
  input wire logic tx_byte_take_q,
  input wire logic tx_retry_q,
  input wire logic tx_done_q,
  input wire logic tx_excess_coll_q,
  input wire logic [4:0] tx_attempts_q,
  input wire logic data_width_select,
  input wire logic [31:0] rx_word_q,
  input wire logic rx_word_valid_q,
  input wire logic rx_done_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_ext_route; external_codec_select [*8] |-> !int_tx_en_q; endproperty
  a_ext_route: assert property (p_ext_route) else $error("internal pair active");
  property p_int_route; !external_codec_select [*8] |-> !ext_tx_en_q; endproperty
  a_int_route: assert property (p_int_route) else $error("external pair active");
  property p_defer; tx_start && !int_tx_en_q && !ext_tx_en_q |=> !(int_tx_en_q || ext_tx_en_q) [*8]; endproperty
  a_defer: assert property (p_defer) else $error("sent without gap");
  property p_retry; tx_retry_q |=> !(int_tx_en_q || ext_tx_en_q) [*8]; endproperty
  a_retry: assert property (p_retry) else $error("retry without deferral");
  property p_take; tx_byte_take_q |-> int_tx_en_q || ext_tx_en_q; endproperty
  a_take: assert property (p_take) else $error("byte taken while silent");
  property p_done; tx_done_q |=> !tx_done_q; endproperty
  a_done: assert property (p_done) else $error("done not a pulse");
  property p_excess; tx_done_q && tx_excess_coll_q |-> tx_attempts_q == 5'h10; endproperty
  a_excess: assert property (p_excess) else $error("excess before sixteen");
  property p_narrow; rx_word_valid_q && !data_width_select |-> rx_word_q[31:16] == 16'h0000; endproperty
  a_narrow: assert property (p_narrow) else $error("upper lines used");
  property p_rx_done; rx_done_q |=> !rx_done_q; endproperty
  a_rx_done: assert property (p_rx_done) else $error("rx done not a pulse");
endmodule : cmac_core_asserts
bind cmac_core cmac_core_asserts chk_i (.*);
`default_nettype wire

// >>> dv/cmac_codec_model.sv
/*
  Codec model: free 10 MHz transmit clock, captures sent bits, plays receive frames.
  Receive clock stands still between frames.
*/
`timescale 1ns/10ps
`default_nettype none
module cmac_codec_model (
  input wire logic txd,
  input wire logic txen,
  output logic transmit_bit_clock,
  output logic rxc,
  output logic rxd,
  output logic carrier_sense_in
);
  logic bits[$];
  initial begin
    transmit_bit_clock = 1'b0;
    rxc = 1'b0;
    rxd = 1'b0;
    carrier_sense_in = 1'b0;
  end
  always #50 transmit_bit_clock = ~transmit_bit_clock;
  // Mid-bit sampling, the core launches data a few cycles after the rise
  always @(negedge transmit_bit_clock) if (txen) bits.push_back(txd);
  task automatic send(input logic [7:0] b[$]);
    int i;
    b.push_front(8'hD5);
    repeat (7) b.push_front(8'h55);
    carrier_sense_in = 1'b1;
    for (i = 0; i < 8 * b.size(); i++) begin
      rxd = b[i / 8][i % 8];
      #50 rxc = 1'b1;
      #50 rxc = 1'b0;
    end
    carrier_sense_in = 1'b0;
    rxd = ~rxd;
  endtask : send
endmodule : cmac_codec_model
`default_nettype wire

// >>> dv/cmac_core_test.sv
/*
  Bench for cmac_core: transmit framing, collision retry, receive filtering and packing.
  The codec model feeds both pin pairs, so either route is live; slot time shortened.
*/
`timescale 1ns/10ps
`default_nettype none
module cmac_core_test;
  int idx, nb, i, k, cyc, error_cnt, checks;
  logic core_clk = 1'b0, rst_b = 1'b0, external_codec_select = 1'b0, tx_start = 1'b0, tx_crc_inhibit = 1'b0;
  logic col = 1'b0, tbl_wr_en = 1'b0, data_width_select = 1'b1, byte_order_select = 1'b0, tx_byte_valid = 1'b1;
  logic loopback_transceiver = 1'b0, reject_on_collision = 1'b0, reject_on_error = 1'b0;
  logic rx_fifo_overrun = 1'b0, no_free_buffer = 1'b0, jam;
  logic [3:0] tbl_wr_idx = 4'h0;
  logic [47:0] tbl_wr_addr = 48'h0;
  logic int_tx_data_q, int_tx_en_q, ext_tx_data_q, ext_tx_en_q, tx_byte_take_q, tx_retry_q, tx_done_q;
  logic tx_ok_q, tx_excess_coll_q, tx_underrun_q, monitored_frame_bad_q, rx_word_valid_q, rx_done_q;
  logic rx_abort_q, rx_crc_err_q, rx_align_err_q, rx_runt_q;
  logic [4:0] tx_attempts_q;
  logic [31:0] rx_word_q, fc;
  logic [31:0] words[$];
  logic [7:0] q[$];
  logic [31:0] ew[5] = '{32'h04030201, 32'h01020304, 32'h00000201, 32'h04030201, 32'h00000000};
  wire logic transmit_bit_clock, rxc, rxd, carrier_sense_in;
  wire logic [7:0] tx_byte = 8'hA0 + 8'(idx);
  wire logic tx_last = (idx == nb - 1);
  cmac_core #(.SLOT_CYC(20)) uut (.*, .int_rx_data(rxd), .ext_rx_data(rxd), .int_rx_clk(rxc), .ext_rx_clk(rxc),
    .int_carrier_sense_in(carrier_sense_in), .ext_carrier_sense_in(carrier_sense_in), .int_collision(col), .ext_collision(col),
    .int_transmit_bit_clock(transmit_bit_clock), .ext_transmit_bit_clock(transmit_bit_clock));
  cmac_codec_model cdc (.txd(int_tx_data_q | ext_tx_data_q), .txen(int_tx_en_q | ext_tx_en_q), .transmit_bit_clock(transmit_bit_clock),
    .rxc(rxc), .rxd(rxd), .carrier_sense_in(carrier_sense_in));
  always #5 core_clk = ~core_clk;
  // Source rewinds on retry so the resent frame starts from its first byte
  always @(negedge core_clk) begin
    if (tx_retry_q) idx <= 0;
    else if (tx_byte_take_q) idx <= idx + 1;
    if (rx_word_valid_q) words.push_back(rx_word_q);
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic start_tx(input int n);
    nb = n;
    idx = 0;
    cdc.bits.delete();
    tx_start = 1'b1;
    @(negedge core_clk);
    tx_start = 1'b0;
  endtask : start_tx
  task automatic wait_done(input logic [2:0] e);
    wait (tx_done_q === 1'b1);
    @(negedge core_clk);
    chk("tx_ok", {tx_ok_q, tx_excess_coll_q, tx_underrun_q}, e);
    // The last bit reaches the codec up to one bit time after done
    repeat (12) @(negedge core_clk);
  endtask : wait_done
  function automatic logic ebit(input int n);
    logic [7:0] b;
    b = 8'hA0 + 8'((n - 64) / 8);
    return (n < 64) ? (~n[0] | (n >= 62)) : b[(n - 64) % 8];
  endfunction : ebit
  function automatic logic [31:0] fcs(input logic [7:0] b[$]);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (b[j]) for (int m = 0; m < 8; m++) c = (c >> 1) ^ ((c[0] ^ b[j][m]) ? 32'hEDB88320 : 32'h0);
    return ~c;
  endfunction : fcs
  initial begin
    repeat (16) @(negedge core_clk);
    chk("reset", {int_tx_data_q, ext_tx_data_q, int_tx_en_q, ext_tx_en_q, tx_byte_take_q, tx_retry_q, tx_done_q,
      rx_done_q, tx_attempts_q, monitored_frame_bad_q, rx_word_valid_q, rx_abort_q}, 32'h0);
    rst_b = 1'b1;
    tbl_wr_en = 1'b1;
    tbl_wr_addr = 48'h665544332211;
    external_codec_select = 1'b1;
    tx_crc_inhibit = 1'b1;
    @(negedge core_clk);
    tbl_wr_en = 1'b0;
    start_tx(2);
    wait_done(3'h4);
    chk("bit_cnt", cdc.bits.size(), 80);
    for (i = 0; i < 80; i++) chk("bit", cdc.bits[i], ebit(i));
    external_codec_select = 1'b0;
    tx_crc_inhibit = 1'b0;
    start_tx(4);
    while (cdc.bits.size() < 72) @(negedge core_clk);
    col = 1'b1;
    repeat (30) @(negedge core_clk);
    col = 1'b0;
    wait (tx_retry_q === 1'b1);
    jam = 1'b1;
    for (i = 1; i <= 32; i++) jam &= cdc.bits[cdc.bits.size() - i];
    chk("jam", jam, 1);
    chk("attempts", tx_attempts_q, 1);
    cdc.bits.delete();
    wait_done(3'h4);
    chk("fcs_cnt", cdc.bits.size(), 128);
    for (k = 0; k < 5; k++) begin
      byte_order_select = (k == 1);
      data_width_select = (k != 2);
      q = {};
      for (i = 0; i < 12; i++) q.push_back(i < 6 ? (k == 3 ? 8'hFF : (k == 4 ? 8'h77 : 8'(17 * (i + 1)))) : 8'(i - 5));
      fc = fcs(q);
      if (k == 0) for (i = 0; i < 4; i++) q.push_back(fc[8 * i +: 8]);
      words.delete();
      cdc.send(q);
      wait (rx_done_q === 1'b1);
      @(negedge core_clk);
      chk("abort", rx_abort_q, k == 4);
      chk("runt", {rx_runt_q, rx_align_err_q}, 2'h2);
      if (k < 4) chk("crc_err", rx_crc_err_q, k != 0);
      chk("word0", words.size() > 0 ? words[0] : 32'h0, ew[k]);
      repeat (50) @(negedge core_clk);
    end
    tx_byte_valid = 1'b0;
    start_tx(1);
    wait_done(3'h1);
    chk("und_cnt", cdc.bits.size(), 64);
    stop_test();
  end
endmodule : cmac_core_test
`default_nettype wire
